//--- mnp_exec_pkg.sv
/*
  Shared constants for the multiply, negate, no-operation and pop
  execution block: opcodes, status flag positions, register port
  offsets, reset values and the instruction phase encoding.
  Assumes a single core clock and a plain register port.
*/
// Function
// - Multiply-by-literal stores unsigned W times literal in the product pair.
// - Both multiplies keep W and all status flags unchanged.
// - Multiply-by-file stores W times file register, sources untouched.
// - Bank bit 0 picks access bank; bank bit 1 uses bank select register.
// - Access mode with extended set and address up to 95 uses indexed offset.
// - Negate replaces the file register with its two's complement.
// - Negate updates N, OV, C, DC, Z; others leave flags alone.
// - Pop discards the stack top entry in one single-word cycle.
package mnp_exec_pkg;

  localparam logic [7:0]  OPC_MUL_LIT_HI   = 8'h0D;
  localparam logic [6:0]  OPC_MUL_FILE_HI  = 7'h01;
  localparam logic [6:0]  OPC_NEG_FILE_HI  = 7'h36;
  localparam logic [15:0] OPC_POP          = 16'h0006;
  localparam logic [15:0] OPC_NOP_ZERO     = 16'h0000;
  localparam logic [3:0]  OPC_NOP_TOP      = 4'hF;

  localparam int          BANK_BIT         = 8;
  localparam logic [7:0]  INDEXED_LAST     = 8'h5F;
  localparam logic [3:0]  ACCESS_LOW_PAGE  = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH_PAGE = 4'hF;

  localparam int          STAT_C           = 0;
  localparam int          STAT_DC          = 1;
  localparam int          STAT_Z           = 2;
  localparam int          STAT_OV          = 3;
  localparam int          STAT_N           = 4;
  localparam int          STAT_W           = 5;

  localparam logic [3:0]  REG_WORKING      = 4'h0;
  localparam logic [3:0]  REG_BANK_SELECT  = 4'h1;
  localparam logic [3:0]  REG_STATUS       = 4'h2;
  localparam logic [3:0]  REG_PRODUCT_LOW  = 4'h3;
  localparam logic [3:0]  REG_PRODUCT_HIGH = 4'h4;
  localparam logic [3:0]  REG_CONTROL      = 4'h5;
  localparam logic [3:0]  REG_STACK_PTR    = 4'h6;
  localparam int          CTRL_EXTENDED    = 0;

  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [3:0]  RST_BANK         = 4'h0;
  localparam logic [4:0]  RST_STATUS       = 5'h00;
  localparam logic [15:0] RST_PRODUCT      = 16'h0000;

  typedef enum logic [3:0] {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE   = 4'b1000
  } phase_t;

  typedef enum logic [4:0] {
    OP_NONE     = 5'b00001,
    OP_MUL_LIT  = 5'b00010,
    OP_MUL_FILE = 5'b00100,
    OP_NEG_FILE = 5'b01000,
    OP_POP      = 5'b10000
  } op_class_t;

endpackage : mnp_exec_pkg

//--- quarter_tick_divider.sv
/*
  Divider that marks the last core clock of each quarter cycle with a
  one-cycle tick.
  Assumes an active-low reset from the parent, applied asynchronously and released in step with the clock.
*/
`timescale 1ns/10ps
module quarter_tick_divider #(
  parameter int CLOCKS_PER_QUARTER = 1
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  localparam int CW = (CLOCKS_PER_QUARTER > 1) ?
                      $clog2(CLOCKS_PER_QUARTER) : 1;
  localparam logic [CW-1:0] LAST = CW'(CLOCKS_PER_QUARTER - 1);

  logic [CW-1:0] count_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end

  assign tick_out = (count_reg == LAST);

endmodule : quarter_tick_divider

//--- negate_unit.sv
/*
  Two's complement negation of one byte with the arithmetic flags that
  the result produces, as if computed as zero minus the operand.
  Purely combinational; the parent latches the outputs.
*/
`timescale 1ns/10ps
module negate_unit
  import mnp_exec_pkg::*;
(
  input  wire logic [7:0]      operand_in,
  output logic      [7:0]      result_out,
  output logic      [STAT_W-1:0] flags_out
);

  assign result_out = (~operand_in) + 8'h01;

  always_comb begin
    flags_out          = '0;
    flags_out[STAT_C]  = (operand_in == 8'h00);
    flags_out[STAT_DC] = (operand_in[3:0] == 4'h0);
    flags_out[STAT_Z]  = (result_out == 8'h00);
    flags_out[STAT_OV] = (operand_in == 8'h80);
    flags_out[STAT_N]  = result_out[7];
  end

endmodule : negate_unit

//--- multiply_negate_pop_exec.sv
/*
  Execution block for multiply by literal, multiply by file register,
  negate file register, no operation and pop of the return stack.
  Assumes instruction words and data memory answers come from logic on
  the same clock; data memory returns read data one cycle after the
  read strobe.
*/
`timescale 1ns/10ps
module multiply_negate_pop_exec
  import mnp_exec_pkg::*;
#(
  parameter int CLOCKS_PER_QUARTER = 1,
  parameter int STACK_PTR_W        = 5
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic [15:0]            instr_word_in,
  input  wire logic                   instr_valid_in,
  output logic                        instr_take_out,
  output logic                        cycle_end_out,
  input  wire logic [11:0]            index_base_in,
  output logic      [11:0]            mem_addr_out,
  output logic                        mem_rd_out,
  input  wire logic [7:0]             mem_rdata_in,
  output logic                        mem_wr_out,
  output logic      [7:0]             mem_wdata_out,
  input  wire logic [3:0]             reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [7:0]             reg_rdata_out,
  output logic                        stack_pop_out,
  output logic      [STACK_PTR_W-1:0] stack_ptr_out,
  output logic      [15:0]            product_out,
  output logic      [STAT_W-1:0]      status_out
);

  import mnp_exec_pkg::*;

  logic [1:0]             rst_sync_reg;
  logic                   rst_n;
  logic                   tick;
  phase_t                 phase_reg;
  op_class_t              op_reg;
  op_class_t              op_next;
  logic [7:0]             literal_reg;
  logic [11:0]            addr_next;
  logic [11:0]            addr_reg;
  logic                   rd_pending_reg;
  logic [7:0]             operand_reg;
  logic [7:0]             operand_now;
  logic [15:0]            calc_reg;
  logic [7:0]             neg_result;
  logic [STAT_W-1:0]      neg_flags;
  logic [7:0]             neg_result_reg;
  logic [STAT_W-1:0]      neg_flags_reg;
  logic [7:0]             working_reg;
  logic [3:0]             bank_reg;
  logic [STAT_W-1:0]      status_reg;
  logic [15:0]            product_reg;
  logic                   extended_reg;
  logic [STACK_PTR_W-1:0] stack_ptr_reg;
  logic [7:0]             rdata_reg;
  logic                   take;
  logic                   process_tick;
  logic                   write_tick;
  logic                   bus_wr_working;
  logic                   bus_wr_bank;
  logic                   bus_wr_status;
  logic                   bus_wr_prod_lo;
  logic                   bus_wr_prod_hi;
  logic                   bus_wr_control;
  logic                   bus_wr_stack;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  quarter_tick_divider #(
    .CLOCKS_PER_QUARTER (CLOCKS_PER_QUARTER)
  ) u_quarter (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .tick_out (tick)
  );

  negate_unit u_negate (
    .operand_in (operand_now),
    .result_out (neg_result),
    .flags_out  (neg_flags)
  );

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PH_DECODE;
    end else if (tick) begin
      unique case (phase_reg)
        PH_DECODE:  phase_reg <= PH_READ;
        PH_READ:    phase_reg <= PH_PROCESS;
        PH_PROCESS: phase_reg <= PH_WRITE;
        PH_WRITE:   phase_reg <= PH_DECODE;
      endcase
    end
  end

  assign take         = tick && (phase_reg == PH_DECODE) && instr_valid_in;
  assign process_tick = tick && (phase_reg == PH_PROCESS);
  assign write_tick   = tick && (phase_reg == PH_WRITE);

  always_comb begin
    op_next = OP_NONE;
    if (instr_word_in == OPC_NOP_ZERO ||
        instr_word_in[15:12] == OPC_NOP_TOP) begin
      op_next = OP_NONE;
    end else if (instr_word_in == OPC_POP) begin
      op_next = OP_POP;
    end else if (instr_word_in[15:8] == OPC_MUL_LIT_HI) begin
      op_next = OP_MUL_LIT;
    end else if (instr_word_in[15:9] == OPC_MUL_FILE_HI) begin
      op_next = OP_MUL_FILE;
    end else if (instr_word_in[15:9] == OPC_NEG_FILE_HI) begin
      op_next = OP_NEG_FILE;
    end
  end

  always_comb begin
    if (instr_word_in[BANK_BIT]) begin
      addr_next = {bank_reg, instr_word_in[7:0]};
    end else if (extended_reg && instr_word_in[7:0] <= INDEXED_LAST) begin
      addr_next = index_base_in + {4'h0, instr_word_in[7:0]};
    end else if (instr_word_in[7:0] <= INDEXED_LAST) begin
      addr_next = {ACCESS_LOW_PAGE, instr_word_in[7:0]};
    end else begin
      addr_next = {ACCESS_HIGH_PAGE, instr_word_in[7:0]};
    end
  end

  // Decode latch; words not offered at decode run as no operation.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      op_reg      <= OP_NONE;
      literal_reg <= RST_BYTE;
      addr_reg    <= 12'h000;
    end else if (tick && phase_reg == PH_DECODE) begin
      op_reg      <= instr_valid_in ? op_next : OP_NONE;
      literal_reg <= instr_word_in[7:0];
      addr_reg    <= addr_next;
    end
  end

  assign instr_take_out = take;
  assign cycle_end_out  = write_tick;
  assign mem_addr_out   = addr_reg;
  assign mem_rd_out     = tick && (phase_reg == PH_READ) &&
                          (op_reg == OP_MUL_FILE || op_reg == OP_NEG_FILE);

  // Operand read in the second quarter.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_pending_reg <= 1'b0;
      operand_reg    <= RST_BYTE;
    end else begin
      rd_pending_reg <= mem_rd_out;
      if (rd_pending_reg) begin
        operand_reg <= mem_rdata_in;
      end else if (tick && phase_reg == PH_READ && op_reg == OP_MUL_LIT) begin
        operand_reg <= literal_reg;
      end
    end
  end

  // Read data bypass keeps one clock per quarter working for file operands.
  assign operand_now = rd_pending_reg ? mem_rdata_in : operand_reg;

  // Processing in the third quarter.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      calc_reg       <= RST_PRODUCT;
      neg_result_reg <= RST_BYTE;
      neg_flags_reg  <= RST_STATUS;
    end else if (process_tick) begin
      calc_reg       <= {8'h00, working_reg} * {8'h00, operand_now};
      neg_result_reg <= neg_result;
      neg_flags_reg  <= neg_flags;
    end
  end

  assign mem_wr_out    = write_tick && (op_reg == OP_NEG_FILE);
  assign mem_wdata_out = neg_result_reg;

  assign stack_pop_out = process_tick && (op_reg == OP_POP);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr_reg <= '0;
    end else if (stack_pop_out) begin
      if (stack_ptr_reg != '0) begin
        stack_ptr_reg <= stack_ptr_reg - STACK_PTR_W'(1);
      end
    end else if (bus_wr_stack) begin
      stack_ptr_reg <= reg_wdata_in[STACK_PTR_W-1:0];
    end
  end

  assign bus_wr_working = reg_wr_in && (reg_addr_in == REG_WORKING);
  assign bus_wr_bank    = reg_wr_in && (reg_addr_in == REG_BANK_SELECT);
  assign bus_wr_status  = reg_wr_in && (reg_addr_in == REG_STATUS);
  assign bus_wr_prod_lo = reg_wr_in && (reg_addr_in == REG_PRODUCT_LOW);
  assign bus_wr_prod_hi = reg_wr_in && (reg_addr_in == REG_PRODUCT_HIGH);
  assign bus_wr_control = reg_wr_in && (reg_addr_in == REG_CONTROL);
  assign bus_wr_stack   = reg_wr_in && (reg_addr_in == REG_STACK_PTR);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      working_reg <= RST_BYTE;
    end else if (bus_wr_working) begin
      working_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg     <= RST_BANK;
      extended_reg <= 1'b0;
    end else begin
      if (bus_wr_bank) begin
        bank_reg <= reg_wdata_in[3:0];
      end
      if (bus_wr_control) begin
        extended_reg <= reg_wdata_in[CTRL_EXTENDED];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= RST_STATUS;
    end else if (write_tick && op_reg == OP_NEG_FILE) begin
      status_reg <= neg_flags_reg;
    end else if (bus_wr_status) begin
      status_reg <= reg_wdata_in[STAT_W-1:0];
    end
  end

  // Product pair written in the fourth quarter.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      product_reg <= RST_PRODUCT;
    end else if (write_tick &&
                 (op_reg == OP_MUL_LIT || op_reg == OP_MUL_FILE)) begin
      product_reg <= calc_reg;
    end else begin
      if (bus_wr_prod_lo) begin
        product_reg[7:0] <= reg_wdata_in;
      end
      if (bus_wr_prod_hi) begin
        product_reg[15:8] <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RST_BYTE;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_WORKING:      rdata_reg <= working_reg;
        REG_BANK_SELECT:  rdata_reg <= {4'h0, bank_reg};
        REG_STATUS:       rdata_reg <= {3'b000, status_reg};
        REG_PRODUCT_LOW:  rdata_reg <= product_reg[7:0];
        REG_PRODUCT_HIGH: rdata_reg <= product_reg[15:8];
        REG_CONTROL:      rdata_reg <= {7'h00, extended_reg};
        REG_STACK_PTR:    rdata_reg <= 8'(stack_ptr_reg);
        default:          rdata_reg <= RST_BYTE;
      endcase
    end else begin
      rdata_reg <= RST_BYTE;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign stack_ptr_out = stack_ptr_reg;
  assign product_out   = product_reg;
  assign status_out    = status_reg;

endmodule : multiply_negate_pop_exec

//--- mnp_exec_assertions.sv
/*
  Checker for the multiply, negate, no-operation and pop block.
  Bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module mnp_exec_checker
  import mnp_exec_pkg::*;
#(
  parameter int CLOCKS_PER_QUARTER = 1,
  parameter int STACK_PTR_W        = 5
) (
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   instr_take_out,
  input wire logic                   cycle_end_out,
  input wire logic                   mem_rd_out,
  input wire logic [7:0]             mem_rdata_in,
  input wire logic                   mem_wr_out,
  input wire logic [7:0]             mem_wdata_out,
  input wire logic [3:0]             reg_addr_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [7:0]             reg_rdata_out,
  input wire logic                   stack_pop_out,
  input wire logic [STACK_PTR_W-1:0] stack_ptr_out,
  input wire logic [15:0]            product_out,
  input wire logic [STAT_W-1:0]      status_out
);
  localparam int Q1 = CLOCKS_PER_QUARTER;
  localparam int Q2 = 2 * CLOCKS_PER_QUARTER;
  localparam int Q3 = 3 * CLOCKS_PER_QUARTER;
  localparam int RW = 2 * CLOCKS_PER_QUARTER - 1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  take_end_a: assert property (instr_take_out |-> ##Q3 cycle_end_out)
    else $error("cycle end not three quarters after decode");
  read_slot_a: assert property (mem_rd_out |-> $past(instr_take_out, Q1))
    else $error("operand read outside read quarter");
  neg_order_a: assert property (mem_wr_out |-> $past(mem_rd_out, Q2))
    else $error("memory write without read two quarters before");
  neg_data_a: assert property (mem_wr_out |->
    mem_wdata_out == 8'h00 - $past(mem_rdata_in, RW))
    else $error("written byte is not the negated operand");
  neg_flags_a: assert property (mem_wr_out |=>
    status_out[STAT_Z] == (mem_wdata_out == 8'h00) &&
    status_out[STAT_C] == (mem_wdata_out == 8'h00) &&
    status_out[STAT_N] == mem_wdata_out[7])
    else $error("negate flags do not match result");
  pop_slot_a: assert property (stack_pop_out |-> $past(instr_take_out, Q2))
    else $error("pop outside process quarter");
  pop_ptr_a: assert property (stack_pop_out && stack_ptr_out != '0 |=>
    stack_ptr_out == $past(stack_ptr_out) - 1'b1)
    else $error("pop did not step the stack pointer");
  prod_hold_a: assert property ($changed(product_out) |->
    $past(cycle_end_out) || $past(reg_wr_in))
    else $error("product changed outside write quarter");
  rd_prod_a: assert property ($past(reg_rd_in) &&
    $past(reg_addr_in) == REG_PRODUCT_LOW |->
    reg_rdata_out == 8'($past(product_out)))
    else $error("product low read mismatch");
  cover property (mem_wr_out);
  cover property (stack_pop_out && stack_ptr_out == '0);
  cover property ($changed(product_out));
endmodule : mnp_exec_checker

bind multiply_negate_pop_exec mnp_exec_checker #(
  .CLOCKS_PER_QUARTER(CLOCKS_PER_QUARTER), .STACK_PTR_W(STACK_PTR_W)
) chk (.clk_in, .rst_n_in, .instr_take_out, .cycle_end_out, .mem_rd_out,
  .mem_rdata_in, .mem_wr_out, .mem_wdata_out, .reg_addr_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .stack_pop_out, .stack_ptr_out,
  .product_out, .status_out);

//--- multiply_negate_pop_exec_bench.sv
/*
  Self-checking bench for the multiply, negate, no-operation and pop
  block; a memory array answers the data port.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/10ps
module multiply_negate_pop_exec_bench;
  import mnp_exec_pkg::*;
  logic        clk_in = 0, rst_n_in = 0, instr_valid_in = 0, ext;
  logic        reg_wr_in = 0, reg_rd_in = 0, mem_rd_out, mem_wr_out;
  logic        instr_take_out, cycle_end_out, stack_pop_out;
  logic [15:0] instr_word_in = 0, product_out, word, prod = 0;
  logic [11:0] index_base_in = 0, mem_addr_out, ea;
  logic [7:0]  mem_rdata_in = 0, mem_wdata_out, reg_wdata_in = 0;
  logic [7:0]  reg_rdata_out, d, v, res, w, f;
  logic [3:0]  reg_addr_in = 0, bank;
  logic [4:0]  stack_ptr_out, status_out, st = 0, sp;
  logic [7:0]  mem [4096];
  logic [31:0] seed = 32'h0000_1e06, r;
  int          err_count = 0, samples_checked = 0, k;

  multiply_negate_pop_exec #(.CLOCKS_PER_QUARTER(2)) DUT (.clk_in,
    .rst_n_in, .instr_word_in, .instr_valid_in, .instr_take_out,
    .cycle_end_out, .index_base_in, .mem_addr_out, .mem_rd_out,
    .mem_rdata_in, .mem_wr_out, .mem_wdata_out, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .stack_pop_out, .stack_ptr_out, .product_out, .status_out);

  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (mem_wr_out)
      mem[mem_addr_out] <= mem_wdata_out;
    mem_rdata_in <= mem_rd_out ? mem[mem_addr_out] : ~mem_rdata_in;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] dv);
    reg_addr_in <= a;
    reg_wdata_in <= dv;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
    q = reg_rdata_out;
  endtask : rd

  task automatic exec(input logic [15:0] iw);
    int n;
    n = 0;
    instr_word_in <= iw;
    instr_valid_in <= 1'b1;
    do begin
      @(negedge clk_in);
      n++;
    end while (instr_take_out !== 1'b1 && n < 40);
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    while (cycle_end_out !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 40)
      err_count++;
    repeat (2) @(posedge clk_in);
  endtask : exec

  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    complete_run();
  end

  initial begin
    for (k = 0; k < 4096; k++) begin
      r = rnd();
      mem[k] = r[7:0];
    end
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    for (k = 0; k < 8; k++) begin
      rd(k[3:0], d);
      chk(16'(d), 16'h0000);
    end
    sp = 5'h05;
    wr(REG_STACK_PTR, 8'h05);
    for (k = 0; k < 70; k++) begin
      r = rnd();
      if (k % 5 == 0) begin
        w = r[31:24];
        bank = r[23:20];
        ext = r[19];
        wr(REG_WORKING, w);
        wr(REG_BANK_SELECT, {4'h0, bank});
        wr(REG_CONTROL, {7'h00, ext});
      end
      index_base_in <= r[31:20];
      case (k % 7)
        0: word = {OPC_MUL_LIT_HI, r[7:0]};
        1: word = {OPC_MUL_FILE_HI, r[8:0]};
        2: word = {OPC_NEG_FILE_HI, r[8:0]};
        3: word = OPC_POP;
        4: word = OPC_NOP_ZERO;
        5: word = {OPC_NOP_TOP, r[11:0]};
        default: word = {OPC_NEG_FILE_HI, 1'b0, (k % 2) ? 8'h5F : 8'h60};
      endcase
      f = word[7:0];
      ea = word[8] ? {bank, f} : (ext && f <= 8'h5F) ? r[31:20] + 12'(f)
           : {(f > 8'h5F) ? 4'hF : 4'h0, f};
      if (k % 7 == 6)
        mem[ea] = (k % 3 == 0) ? 8'h80 : (k % 3 == 1) ? 8'h00 : 8'h10;
      v = mem[ea];
      exec(word);
      case (k % 7)
        0: prod = w * word[7:0];
        1: begin
          prod = w * v;
          chk(16'(mem[ea]), 16'(v));
        end
        2, 6: begin
          res = 8'h00 - v;
          st = {res[7], v == 8'h80, res == 8'h00, v[3:0] == 4'h0, v == 8'h00};
          chk(16'(mem[ea]), 16'(res));
        end
        3: sp = (sp == 5'h00) ? sp : sp - 5'h01;
        default: ;
      endcase
      chk(product_out, prod);
      chk(16'(status_out), 16'(st));
      chk(16'(stack_ptr_out), 16'(sp));
      rd(REG_PRODUCT_HIGH, d);
      chk(16'(d), 16'(prod[15:8]));
      rd(REG_PRODUCT_LOW, d);
      chk(16'(d), 16'(prod[7:0]));
      rd(REG_WORKING, d);
      chk(16'(d), 16'(w));
    end
    complete_run();
  end
endmodule : multiply_negate_pop_exec_bench
